// ### design/slds_pkg.sv
// constants, register map and state codes of the length-switching serial sequencer
package slds_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SCK_HZ = 125_000;
    localparam int SCK_HALF_CYC = CLK_HZ / (2 * SCK_HZ);
    localparam int LEN24 = 24;
    localparam int LEN16 = 16;
    localparam logic [3:0] CNT24 = 4'h1;
    localparam logic [3:0] CNT16 = 4'h8;

    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TX24 = 12'h008;
    localparam logic [11:0] OFS_TX16 = 12'h00c;
    localparam logic [11:0] OFS_RX24 = 12'h010;
    localparam logic [11:0] OFS_RX16 = 12'h020;

    localparam int CTRL_EN = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_BUSY = 0;
    localparam int ST_PHASE16 = 1;
    localparam int ST_SELECT = 2;
    localparam int ST_TXREQ = 4;
    localparam int ST_RXREQ = 5;
    localparam int ST_CEREQ = 6;
    localparam int ST_TXCNT = 8;
    localparam int ST_RXCNT = 12;
    localparam int ST_FRAMES = 16;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN24 = 2'b01,
        SEQ_RUN16 = 2'b10
    } slds_seq_e;

    typedef enum logic [2:0] {
        REG_NONE = 3'b000,
        REG_CTRL = 3'b001,
        REG_STATUS = 3'b010,
        REG_TX24 = 3'b011,
        REG_TX16 = 3'b100,
        REG_RX24 = 3'b101,
        REG_RX16 = 3'b110
    } slds_reg_e;
endpackage : slds_pkg

// ### design/slds_top.sv
// serial master with descriptor-fed 24-bit / 8x16-bit exchange and apb slave
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module slds_top
    import slds_pkg::*;
#(
    parameter int SCK_HALF = SCK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic push_button_n,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic select_port_pin
);
    localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
    localparam logic [4:0] LAST24 = 5'(LEN24 - 1);
    localparam logic [4:0] LAST16 = 5'(LEN16 - 1);

    typedef struct packed {
        slds_seq_e seq;
        logic enable;
        logic len16;
        logic select_pin;
        logic tx_en;
        logic ce_en;
        logic [3:0] tx_cnt;
        logic [3:0] rx_cnt;
        logic [2:0] rx_ptr;
        logic tx_full;
        logic [23:0] tx_buf;
        logic rx_full;
        logic [23:0] rx_buf;
        logic [31:0] tx24;
        logic [15:0] tx16;
        logic [23:0] rx24;
        logic [7:0][15:0] rx16;
        logic tx_req;
        logic rx_req;
        logic ce_req;
        logic [3:0] frames;
        logic eng_busy;
        logic sck;
        logic mosi;
        logic [4:0] bit_cnt;
        logic [7:0] div_cnt;
        logic [23:0] shifter;
        logic miso_s1;
        logic miso_s2;
        logic btn_s1;
        logic btn_s2;
        logic btn_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } slds_state_s;

    slds_state_s s;
    slds_state_s next_s;
    logic [23:0] shifted;
    logic [31:0] rd_data;
    slds_reg_e rd_sel;
    slds_reg_e wr_sel;
    logic apb_wr;
    logic btn_fall;
    logic tx_move;
    logic tx_pass;
    logic rx_move;
    logic comm_end_irq;

    // register select shared by read and write paths
    function automatic slds_reg_e reg_decode(input logic [11:0] a);
        slds_reg_e r;
        r = REG_NONE;
        if (a == OFS_CTRL) begin
            r = REG_CTRL;
        end else if (a == OFS_STATUS) begin
            r = REG_STATUS;
        end else if (a == OFS_TX24) begin
            r = REG_TX24;
        end else if (a == OFS_TX16) begin
            r = REG_TX16;
        end else if (a == OFS_RX24) begin
            r = REG_RX24;
        end else if (a[11:5] == OFS_RX16[11:5] && a[1:0] == 2'b00) begin
            r = REG_RX16;
        end
        return r;
    endfunction : reg_decode

    assign rd_sel = reg_decode(paddr);
    assign wr_sel = reg_decode(paddr);
    assign apb_wr = psel && penable && s.pready && pwrite;
    assign btn_fall = s.btn_prev && !s.btn_s2;
    assign tx_move = s.seq != SEQ_IDLE && s.tx_en && !s.tx_full
        && s.tx_cnt != 4'h0;
    assign tx_pass = s.seq != SEQ_IDLE && s.tx_en && !s.tx_full
        && s.tx_cnt == 4'h0;
    assign rx_move = s.rx_full && s.rx_cnt != 4'h0;
    assign comm_end_irq = !s.eng_busy && !s.tx_full && !s.rx_full;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_sel == REG_CTRL) begin
            rd_data[CTRL_EN] = s.enable;
        end else if (rd_sel == REG_STATUS) begin
            rd_data[ST_BUSY] = s.seq != SEQ_IDLE;
            rd_data[ST_PHASE16] = s.len16;
            rd_data[ST_SELECT] = s.select_pin;
            rd_data[ST_TXREQ] = s.tx_req;
            rd_data[ST_RXREQ] = s.rx_req;
            rd_data[ST_CEREQ] = s.ce_req;
            rd_data[ST_TXCNT +: 4] = s.tx_cnt;
            rd_data[ST_RXCNT +: 4] = s.rx_cnt;
            rd_data[ST_FRAMES +: 4] = s.frames;
        end else if (rd_sel == REG_TX24) begin
            rd_data = s.tx24;
        end else if (rd_sel == REG_TX16) begin
            rd_data = {16'h0000, s.tx16};
        end else if (rd_sel == REG_RX24) begin
            rd_data = {8'h00, s.rx24};
        end else if (rd_sel == REG_RX16) begin
            rd_data = {16'h0000, s.rx16[paddr[4:2]]};
        end
    end

    always_comb begin
        next_s = s;
        shifted = {s.shifter[22:0], s.miso_s2};
        next_s.miso_s1 = spi_miso;
        next_s.miso_s2 = s.miso_s1;
        next_s.btn_s1 = push_button_n;
        next_s.btn_s2 = s.btn_s1;
        next_s.btn_prev = s.btn_s2;

        // apb: zero-wait answer in the first access cycle
        next_s.pready = 1'b0;
        if (psel && !penable) begin
            next_s.pready = 1'b1;
            next_s.pslverr = rd_sel == REG_NONE;
            next_s.prdata = rd_data;
        end
        if (apb_wr) begin
            if (wr_sel == REG_CTRL) begin
                next_s.enable = pwdata[CTRL_EN];
            end else if (wr_sel == REG_STATUS) begin
                // write one to clear; later hardware sets win
                if (pwdata[ST_TXREQ]) next_s.tx_req = 1'b0;
                if (pwdata[ST_RXREQ]) next_s.rx_req = 1'b0;
                if (pwdata[ST_CEREQ]) next_s.ce_req = 1'b0;
            end else if (wr_sel == REG_TX24) begin
                next_s.tx24 = pwdata;
            end else if (wr_sel == REG_TX16) begin
                next_s.tx16 = pwdata[15:0];
            end
        end

        // transmit descriptor, fixed source into the data buffer
        if (tx_move) begin
            next_s.tx_full = 1'b1;
            next_s.tx_cnt = s.tx_cnt - 4'h1;
            if (s.len16) begin
                next_s.tx_buf = {8'h00, s.tx16};
            end else begin
                next_s.tx_buf = s.tx24[23:0];
            end
        end else if (tx_pass) begin
            next_s.tx_req = 1'b1;
            next_s.tx_en = 1'b0;
        end

        // receive descriptor; cpu told on the last move or a spare event
        if (rx_move) begin
            next_s.rx_full = 1'b0;
            next_s.rx_cnt = s.rx_cnt - 4'h1;
            if (s.len16) begin
                next_s.rx16[s.rx_ptr] = s.rx_buf[15:0];
                next_s.rx_ptr = s.rx_ptr + 3'h1;
            end else begin
                next_s.rx24 = s.rx_buf;
            end
            if (s.rx_cnt == 4'h1) begin
                next_s.rx_req = 1'b1;
                next_s.ce_en = 1'b1;
            end
        end else if (s.rx_full) begin
            next_s.rx_full = 1'b0;
            next_s.rx_req = 1'b1;
            next_s.ce_en = 1'b1;
        end

        // shift engine: change on rising edge, sample on falling edge
        if (s.eng_busy) begin
            if (s.div_cnt == HALF_M1) begin
                next_s.div_cnt = 8'h00;
                next_s.sck = !s.sck;
                if (!s.sck) begin
                    next_s.mosi = s.len16 ? s.shifter[15] : s.shifter[23];
                end else begin
                    next_s.shifter = shifted;
                    next_s.bit_cnt = s.bit_cnt + 5'h01;
                    if (s.bit_cnt == (s.len16 ? LAST16 : LAST24)) begin
                        next_s.eng_busy = 1'b0;
                        next_s.rx_full = 1'b1;
                        next_s.frames = s.frames + 4'h1;
                        if (s.len16) begin
                            next_s.rx_buf = {8'h00, shifted[15:0]};
                        end else begin
                            next_s.rx_buf = shifted;
                        end
                    end
                end
            end else begin
                next_s.div_cnt = s.div_cnt + 8'h01;
            end
        end else if (s.tx_full) begin
            next_s.shifter = s.tx_buf;
            next_s.tx_full = 1'b0;
            next_s.eng_busy = 1'b1;
            next_s.bit_cnt = 5'h00;
            next_s.div_cnt = 8'h00;
        end

        // sequencer
        case (s.seq)
            SEQ_IDLE: begin
                if (s.enable && btn_fall) begin
                    next_s.select_pin = 1'b0;
                    next_s.seq = SEQ_RUN24;
                    next_s.tx_en = 1'b1;
                    next_s.frames = 4'h0;
                end
            end
            SEQ_RUN24: begin
                if (s.ce_en && comm_end_irq) begin
                    next_s.ce_req = 1'b1;
                    next_s.ce_en = 1'b0;
                    next_s.len16 = 1'b1;
                    next_s.tx_cnt = CNT16;
                    next_s.rx_cnt = CNT16;
                    next_s.rx_ptr = 3'h0;
                    next_s.tx_en = 1'b1;
                    next_s.frames = 4'h0;
                    next_s.seq = SEQ_RUN16;
                end
            end
            SEQ_RUN16: begin
                if (s.ce_en && comm_end_irq) begin
                    next_s.ce_req = 1'b1;
                    next_s.ce_en = 1'b0;
                    next_s.select_pin = 1'b1;
                    next_s.len16 = 1'b0;
                    next_s.tx_cnt = CNT24;
                    next_s.rx_cnt = CNT24;
                    next_s.rx_ptr = 3'h0;
                    next_s.seq = SEQ_IDLE;
                end
            end
            default: begin
                next_s.seq = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s <= '0;
            s.enable <= CTRL_EN_RST;
            s.select_pin <= 1'b1;
            s.tx_cnt <= CNT24;
            s.rx_cnt <= CNT24;
            s.btn_s1 <= 1'b1;
            s.btn_s2 <= 1'b1;
            s.btn_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign spi_sck = s.sck;
    assign spi_mosi = s.mosi;
    assign select_port_pin = s.select_pin;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_end24;
        s.seq == SEQ_RUN24 ##1 s.seq == SEQ_RUN16;
    endsequence
    sequence s_end16;
        s.seq == SEQ_RUN16 ##1 s.seq == SEQ_IDLE;
    endsequence

    a_rx16_move_incr: assert property (
        (rx_move && s.len16) |=> s.rx_ptr == $past(s.rx_ptr) + 3'h1
            && s.rx16[$past(s.rx_ptr)] == $past(s.rx_buf[15:0]))
        else $error("16-bit receive move wrong");
    a_tx_req_count: assert property (
        $rose(s.tx_req) |-> $past(s.tx_cnt) == 4'h0)
        else $error("transmit cpu request before count used up");
    a_rx_req_count: assert property (
        $rose(s.rx_req) |-> $past(s.rx_cnt) <= 4'h1)
        else $error("receive cpu request before count used up");
    a_button_start: assert property (
        (s.seq == SEQ_IDLE && s.enable && btn_fall)
            |=> !select_port_pin && s.seq == SEQ_RUN24)
        else $error("button did not start 24-bit exchange");
    a_one_frame24: assert property (
        s_end24 |-> $past(s.frames) == 4'h1)
        else $error("24-bit phase frame count not one");
    a_tx24_word: assert property (
        (tx_move && !s.len16) |=> s.tx_full
            && s.tx_buf == $past(s.tx24[23:0]))
        else $error("24-bit transmit word wrong");
    a_tx_disable: assert property (
        tx_pass |=> !s.tx_en [*3])
        else $error("transmit moves not switched off");
    a_ce_enable: assert property (
        (s.rx_full && s.rx_cnt <= 4'h1) |=> s.ce_en || $rose(s.seq[1]))
        else $error("comm end not enabled after receive");
    a_switch16: assert property (
        s_end24 |-> s.len16 && s.tx_cnt == CNT16 && s.rx_cnt == CNT16
            && !select_port_pin && s.tx_en)
        else $error("switch to 16-bit phase wrong");
    a_eight_frames: assert property (
        s_end16 |-> $past(s.frames) == 4'h8)
        else $error("16-bit phase frame count not eight");
    a_tx_pass_cpu: assert property (
        (tx_pass && s.len16) |=> s.tx_req && !s.tx_full)
        else $error("spare transmit event not passed to cpu");
    a_rx_pass_cpu: assert property (
        (s.rx_full && s.rx_cnt == 4'h0) |=> s.rx_req && !s.rx_full)
        else $error("spare receive event not passed to cpu");
    a_restore24: assert property (
        s_end16 |-> select_port_pin && !s.len16 && s.tx_cnt == CNT24
            && s.rx_cnt == CNT24)
        else $error("return to 24-bit idle wrong");
endmodule : slds_top

`default_nettype wire

// ### verification/slds_slave_model.sv
// serial slave model answering the 24-bit frame and eight 16-bit frames
`timescale 1ns/1ps
`default_nettype none

module slds_slave_model #(
    parameter logic [23:0] REPLY24 = 24'h3c5a96,
    parameter logic [15:0] REPLY16 = 16'h5a00
) (
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic select_port_pin,
    output logic spi_miso,
    output logic [23:0] got24,
    output var logic [7:0][15:0] got16,
    output logic [3:0] frames
);
    int bitn = 0;
    int nsel = 0;
    int len;
    logic miso_q = 1'b0;
    logic [23:0] sh_in = 24'h000000;
    logic [23:0] word;

    // released line shows the inverse of the last bit
    assign spi_miso = select_port_pin ? ~miso_q : miso_q;

    initial begin
        frames = 4'h0;
        got24 = 24'h000000;
        got16 = '0;
    end

    always @(negedge select_port_pin) begin
        frames = 4'h0;
        bitn = 0;
        nsel = nsel + 1;
    end

    // first frame of a selection is 24 bits, the rest 16
    // replies change with each selection so stale data shows
    always @(posedge spi_sck) begin
        if (select_port_pin === 1'b0) begin
            len = (frames == 4'h0) ? 24 : 16;
            if (frames == 4'h0) begin
                word = REPLY24 ^ 24'(nsel);
            end else begin
                word = {8'h00, REPLY16 + 16'(frames) + 16'(nsel * 16)};
            end
            miso_q <= word[len - 1 - bitn];
        end
    end

    always @(negedge spi_sck) begin
        if (select_port_pin === 1'b0) begin
            sh_in = {sh_in[22:0], spi_mosi};
            bitn = bitn + 1;
            if (bitn == len) begin
                if (frames == 4'h0) begin
                    got24 = sh_in;
                end else begin
                    got16[frames - 4'h1] = sh_in[15:0];
                end
                frames = frames + 4'h1;
                bitn = 0;
            end
        end
    end
endmodule : slds_slave_model

`default_nettype wire

// ### verification/slds_top_tb.sv
// self-checking bench for the length-switching serial sequencer
`timescale 1ns/1ps
`default_nettype none

module slds_top_tb;
    import slds_pkg::*;
    localparam int LIMIT = 30000;
    localparam logic [23:0] R24 = 24'h3c5a96;
    localparam logic [15:0] R16 = 16'h5a00;
    logic clk_sys, resetn, psel, penable, pwrite, push_button_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rd2;
    logic pready, pslverr, spi_sck, spi_mosi, spi_miso, select_port_pin, err;
    logic [23:0] got24;
    logic [7:0][15:0] got16;
    logic [3:0] frames;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    slds_top #(.SCK_HALF(4)) u_slds_top (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .push_button_n(push_button_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .select_port_pin(select_port_pin));

    slds_slave_model #(.REPLY24(R24), .REPLY16(R16)) u_slds_slave_model (
        .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .select_port_pin(select_port_pin), .spi_miso(spi_miso),
        .got24(got24), .got16(got16), .frames(frames));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // sck may only toggle while the slave is selected
    always @(posedge clk_sys) begin
        if (resetn === 1'b1 && spi_sck === 1'b1) begin
            chk("select_at_sck", 32'h0, {31'h0, select_port_pin});
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n = n + 1;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) begin
            chk("pready", 32'h1, 32'h0);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, rd, err);
        chk(nm, e & m, rd & m);
    endtask : rdchk

    task automatic press();
        @(posedge clk_sys);
        push_button_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        push_button_n <= 1'b1;
    endtask : press

    task automatic wait_until(input int bound, input logic sel,
                              input logic [3:0] f);
        int n;
        n = 0;
        while (!(select_port_pin === sel && frames >= f) && n < bound) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk("wait_bound", 32'h0, {31'h0, n >= bound});
    endtask : wait_until

    task automatic t_reset();
        chk("select_reset", 32'h1, {31'h0, select_port_pin});
        rdchk("ctrl_reset", OFS_CTRL, 32'h1, 32'h1);
        rdchk("status_reset", OFS_STATUS, 32'h1104, 32'hff07);
        $display("test reset done");
    endtask : t_reset

    task automatic t_refuse();
        apb(1'b0, 12'h0fc, 32'h0, rd, err);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        apb(1'b0, OFS_RX24, 32'h0, rd2, err);
        apb(1'b1, OFS_RX24, 32'hffffffff, rd, err);
        rdchk("rx24_readonly", OFS_RX24, rd2, 32'hffffffff);
        apb(1'b1, OFS_CTRL, 32'h0, rd, err);
        press();
        repeat (40) @(posedge clk_sys);
        chk("press_disabled", 32'h1, {31'h0, select_port_pin});
        apb(1'b1, OFS_CTRL, 32'h1, rd, err);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_exchange(input logic [23:0] w24, input logic [15:0] w16,
                              input int n);
        apb(1'b1, OFS_TX24, {8'hff, w24}, rd, err);
        apb(1'b1, OFS_TX16, {16'hffff, w16}, rd, err);
        rdchk("tx24_back", OFS_TX24, {8'hff, w24}, 32'hffffffff);
        rdchk("tx16_back", OFS_TX16, {16'h0, w16}, 32'hffffffff);
        press();
        wait_until(20, 1'b0, 4'h0);
        wait_until(3000, 1'b0, 4'h2);
        rdchk("status_phase16", OFS_STATUS, 32'h3, 32'h7);
        press();
        wait_until(4000, 1'b1, 4'h0);
        chk("frame_count", 32'h9, {28'h0, frames});
        chk("sent24", {8'h0, w24}, {8'h0, got24});
        for (int k = 0; k < 8; k++) begin
            chk("sent16", {16'h0, w16}, {16'h0, got16[k]});
            rdchk("rx16", OFS_RX16 + 12'(4 * k),
                  {16'h0, R16 + 16'(k + 1) + 16'(n * 16)},
                  32'hffff);
        end
        rdchk("rx24", OFS_RX24, {8'h0, R24 ^ 24'(n)}, 32'hffffff);
        rdchk("status_end", OFS_STATUS, 32'h81174,
              32'hfff77);
        apb(1'b1, OFS_STATUS, 32'h70, rd, err);
        rdchk("status_clear", OFS_STATUS, 32'h0, 32'h70);
        $display("test exchange done");
    endtask : t_exchange

    // reset in the middle of the 16-bit phase
    task automatic t_midreset();
        press();
        wait_until(3000, 1'b0, 4'h2);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk("select_midreset", 32'h1, {31'h0, select_port_pin});
        chk("sck_midreset", 32'h0, {31'h0, spi_sck});
        rdchk("status_midreset", OFS_STATUS, 32'h1104,
              32'hfff77);
        $display("test midreset done");
    endtask : t_midreset

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        push_button_n = 1'b1;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_refuse();
        t_exchange(24'ha5c3e1, 16'h1234, 1);
        t_exchange(24'h5a3c0f, 16'h8001, 2);
        t_midreset();
        t_exchange(24'h0f1e2d, 16'h7e81, 4);
        results();
    end
endmodule : slds_top_tb

`default_nettype wire
